// [otfs_top.sv]
// Output terminal function select: maps drive status onto four terminals.
// Assumes status and meas come from logic on hclk; AHB-Lite single slave.
//
// Behaviour
// - Fast terminal mode 0 pulse, 1 switch
// - Selectors accept codes 0..40, documented defaults
// - Code 0 keeps terminal inactive
// - Code 3 active on fault stop
// - Code 4 active on motor overload pre-warning
// - Code 5 active 10 s before overload trip
// - Code 6 zero speed running, off stopped
// - Code 7 zero frequency, also when stopped
// - Code 8 active at upper frequency limit
// - Code 9 at lower limit, off stopped
// - Codes 10, 11 set/designated count reached
// - Code 12 actual length exceeds setpoint
// - Code 13 250 ms pulse per cycle
// - Code 14 running time exceeds threshold
// - Code 15 setpoint beyond limit, limit reached
// - Code 16 torque limit with stall, speed control
// - Code 17 stable, fault free, ready
// - Code 18 active while running
// - Code 19 analog one above analog two
// - Code 20 active in undervoltage
// - Polarity bit inverts terminal level
// - Per terminal delay 0.0..3600.0 s
`timescale 1ns/10ps
`include "otfs_defs.svh"

module otfs_top #(
  parameter int unsigned PLC_PULSE_CYC = `OTFS_PLC_PULSE_CYC,
  parameter int unsigned TENTH_CYC     = `OTFS_TENTH_CYC
) (
  input  wire logic                 hclk,
  input  wire logic                 hresetn,
  input  wire logic                 hsel,
  input  wire logic [31:0]          haddr,
  input  wire logic [1:0]           htrans,
  input  wire logic                 hwrite,
  input  wire logic [2:0]           hsize,
  input  wire logic [31:0]          hwdata,
  input  wire logic                 hready,
  output logic      [31:0]          hrdata,
  output logic                      hreadyout,
  output logic                      hresp,
  input  wire otfs_pkg::otfs_status_t status,
  input  wire otfs_pkg::otfs_meas_t   meas,
  output logic                      fast_terminal,
  output logic                      relay_one,
  output logic                      relay_two,
  output logic                      open_collector_one,
  output logic                      pulse_mode_output
);

  // ----------------------------------------
  // Functions
  // ----------------------------------------
  function automatic logic fn_cmp(input logic [15:0] a, input logic [15:0] b,
                                  input logic strict);
    fn_cmp = strict ? (a > b) : (a >= b);
  endfunction

  // Condition vector index equals function code; bit 0 is tied low
  function automatic logic fn_select(input logic [15:0] code, input logic [20:0] cond);
    fn_select = (code <= `OTFS_CODE_LAST) ? cond[code[4:0]] : 1'b0;
  endfunction

  // Code selector of a register address; bit 2 set when none matches
  function automatic logic [2:0] fn_code_idx(input logic [7:0] addr);
    case (addr)
      `OTFS_A_FSW:  fn_code_idx = 3'h0;
      `OTFS_A_RLY1: fn_code_idx = 3'h1;
      `OTFS_A_RLY2: fn_code_idx = 3'h2;
      `OTFS_A_OC1:  fn_code_idx = 3'h3;
      default:      fn_code_idx = 3'h4;
    endcase
  endfunction

  // Delay register of an address; bit 2 set when none matches
  function automatic logic [2:0] fn_dly_idx(input logic [7:0] addr);
    case (addr)
      `OTFS_A_DLY0: fn_dly_idx = 3'h0;
      `OTFS_A_DLY1: fn_dly_idx = 3'h1;
      `OTFS_A_DLY2: fn_dly_idx = 3'h2;
      `OTFS_A_DLY3: fn_dly_idx = 3'h3;
      default:      fn_dly_idx = 3'h4;
    endcase
  endfunction

  // ----------------------------------------
  // Registers and state
  // ----------------------------------------
  logic [15:0] mode_q;
  logic [15:0] code_q [4];
  logic [3:0]  pol_q;
  logic [15:0] dly_q  [4];
  logic [15:0] cnt_q  [4];
  logic [3:0]  stable_q;
  logic [3:0]  raw;
  logic [20:0] cond;
  logic [23:0] tenth_cnt_q;
  logic        tick_q;
  logic [24:0] plc_cnt_q;
  logic        wr_pend_q;
  logic [7:0]  wr_addr_q;
  logic        rd_pend_q;
  logic [7:0]  rd_addr_q;
  logic [31:0] hrdata_q;
  logic        hreadyout_q;
  logic [3:0]  pins_q;
  logic        pulse_mode_q;
  logic [31:0] rd_val;
  logic        hresp_q;
  logic        wr_take;
  logic        rd_take;
  logic [2:0]  code_sel;
  logic [2:0]  dly_sel;

  // ----------------------------------------
  // Status conditions
  // ----------------------------------------
  always_comb begin
    cond     = '0;
    cond[1]  = status.freq_reached;
    cond[2]  = status.freq_level_detect_one;
    cond[3]  = status.fault_stop;
    cond[4]  = status.motor_ovl_warn;
    cond[5]  = status.drive_ovl_pending &&
               (meas.drive_ovl_eta <= 16'(`OTFS_DRV_OVL_LEAD_DS));
    cond[6]  = status.running && status.freq_zero;
    cond[7]  = status.freq_zero || !status.running;
    cond[8]  = status.running && status.at_upper;
    cond[9]  = status.running && status.at_lower;
    cond[10] = fn_cmp(meas.count, meas.count_set, 1'b0);
    cond[11] = fn_cmp(meas.count, meas.count_desig, 1'b0);
    cond[12] = fn_cmp(meas.length_act, meas.length_set, 1'b1);
    cond[13] = (plc_cnt_q != 25'h0000000);
    cond[14] = fn_cmp(meas.run_time, meas.run_time_limit, 1'b1);
    cond[15] = (status.set_above_upper && status.at_upper) ||
               (status.set_below_lower && status.at_lower);
    cond[16] = status.speed_ctrl && status.torque_at_limit && status.stall;
    cond[17] = status.circuits_stable && !status.fault_present &&
               !status.undervoltage;
    cond[18] = status.running;
    cond[19] = fn_cmp(meas.analog_input_one, meas.analog_input_two, 1'b1);
    cond[20] = status.undervoltage;
  end

  // ----------------------------------------
  // Function selection
  // ----------------------------------------
  // Each terminal picks one condition by its code
  always_comb begin
    raw = 4'h0;
    for (int i = 0; i < 4; i++) begin
      raw[i] = fn_select(code_q[i], cond);
    end
  end

  // ----------------------------------------
  // Sequencer cycle pulse
  // ----------------------------------------
  // A new cycle end during a pulse restarts the full width
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      plc_cnt_q <= 25'h0000000;
    end else if (status.plc_cycle_done) begin
      plc_cnt_q <= 25'(PLC_PULSE_CYC);
    end else if (plc_cnt_q != 25'h0000000) begin
      plc_cnt_q <= plc_cnt_q - 25'h0000001;
    end
  end

  // ----------------------------------------
  // Tenth of a second divider
  // ----------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tenth_cnt_q <= 24'h000000;
      tick_q      <= 1'b0;
    end else if (tenth_cnt_q == 24'(TENTH_CYC - 1)) begin
      tenth_cnt_q <= 24'h000000;
      tick_q      <= 1'b1;
    end else begin
      tenth_cnt_q <= tenth_cnt_q + 24'h000001;
      tick_q      <= 1'b0;
    end
  end

  // ----------------------------------------
  // Output delay
  // ----------------------------------------
  // Free running tick: a delay may come out up to 0.1 s short
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      stable_q <= 4'h0;
      for (int i = 0; i < 4; i++) begin
        cnt_q[i] <= 16'h0000;
      end
    end else begin
      for (int i = 0; i < 4; i++) begin
        if (raw[i] == stable_q[i]) begin
          cnt_q[i] <= 16'h0000;
        end else if (cnt_q[i] >= dly_q[i]) begin
          stable_q[i] <= raw[i];
          cnt_q[i]    <= 16'h0000;
        end else if (tick_q) begin
          cnt_q[i] <= cnt_q[i] + 16'h0001;
        end
      end
    end
  end

  // ----------------------------------------
  // Terminal pins
  // ----------------------------------------
  // In pulse mode the switch path leaves the fast terminal open
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pins_q <= 4'h0;
    end else begin
      pins_q[0]   <= mode_q[0] ? (stable_q[0] ^ pol_q[0]) : 1'b0;
      pins_q[3:1] <= stable_q[3:1] ^ pol_q[3:1];
    end
  end

  // Reset leaves the fast terminal in pulse mode
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pulse_mode_q <= 1'b1;
    end else begin
      pulse_mode_q <= !mode_q[0];
    end
  end

  assign fast_terminal      = pins_q[0];
  assign relay_one          = pins_q[1];
  assign relay_two          = pins_q[2];
  assign open_collector_one = pins_q[3];
  assign pulse_mode_output  = pulse_mode_q;

  // ----------------------------------------
  // AHB-Lite slave
  // ----------------------------------------
  // A transfer starts on a selected, ready NONSEQ or SEQ phase
  assign wr_take = hsel && hready && htrans[1] && hwrite;
  assign rd_take = hsel && hready && htrans[1] && !hwrite;

  // Write data phase never stalls; hwdata is taken at its end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
    end else begin
      wr_pend_q <= wr_take && !rd_pend_q;
      if (wr_take && !rd_pend_q) begin
        wr_addr_q <= haddr[7:0];
      end
    end
  end

  // Reads take one wait state so a write just before is seen
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd_pend_q <= 1'b0;
      rd_addr_q <= 8'h00;
    end else begin
      rd_pend_q <= rd_take && !rd_pend_q;
      if (rd_take && !rd_pend_q) begin
        rd_addr_q <= haddr[7:0];
      end
    end
  end

  // Read data is loaded from the register mux in the wait cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_q    <= 32'h00000000;
      hreadyout_q <= 1'b1;
      hresp_q     <= 1'b0;
    end else begin
      hresp_q <= 1'b0;
      if (rd_pend_q) begin
        hrdata_q    <= rd_val;
        hreadyout_q <= 1'b1;
      end else if (rd_take) begin
        hreadyout_q <= 1'b0;
      end
    end
  end

  assign hrdata    = hrdata_q;
  assign hreadyout = hreadyout_q;
  assign hresp     = hresp_q;

  always_comb begin
    rd_val = 32'h00000000;
    case (rd_addr_q)
      `OTFS_A_MODE: rd_val = {16'h0000, mode_q};
      `OTFS_A_FSW:  rd_val = {16'h0000, code_q[0]};
      `OTFS_A_RLY1: rd_val = {16'h0000, code_q[1]};
      `OTFS_A_RLY2: rd_val = {16'h0000, code_q[2]};
      `OTFS_A_OC1:  rd_val = {16'h0000, code_q[3]};
      `OTFS_A_POL:  rd_val = {28'h0000000, pol_q};
      `OTFS_A_DLY0: rd_val = {16'h0000, dly_q[0]};
      `OTFS_A_DLY1: rd_val = {16'h0000, dly_q[1]};
      `OTFS_A_DLY2: rd_val = {16'h0000, dly_q[2]};
      `OTFS_A_DLY3: rd_val = {16'h0000, dly_q[3]};
      `OTFS_A_STAT: rd_val = {23'h000000, pulse_mode_q, stable_q, raw};
      default:      rd_val = 32'h00000000;
    endcase
  end

  // ----------------------------------------
  // Configuration registers
  // ----------------------------------------
  // Out of range values are dropped, the old setting stays
  assign code_sel = fn_code_idx(wr_addr_q);
  assign dly_sel  = fn_dly_idx(wr_addr_q);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mode_q <= `OTFS_RST_MODE;
    end else if (wr_pend_q && (wr_addr_q == `OTFS_A_MODE)) begin
      if (hwdata[15:0] <= `OTFS_MODE_MAX) begin
        mode_q <= hwdata[15:0];
      end
    end
  end

  // Each selector has its own reset default
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      code_q[0] <= `OTFS_RST_FSW;
      code_q[1] <= `OTFS_RST_RLY1;
      code_q[2] <= `OTFS_RST_RLY2;
      code_q[3] <= `OTFS_RST_OC1;
    end else if (wr_pend_q && !code_sel[2]) begin
      if (hwdata[15:0] <= `OTFS_CODE_MAX) begin
        code_q[code_sel[1:0]] <= hwdata[15:0];
      end
    end
  end

  // Polarity acts on the pin, after the delay
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pol_q <= `OTFS_RST_POL;
    end else if (wr_pend_q && (wr_addr_q == `OTFS_A_POL)) begin
      pol_q <= hwdata[3:0];
    end
  end

  // Delays count in tenths of a second
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int i = 0; i < 4; i++) begin
        dly_q[i] <= `OTFS_RST_DLY;
      end
    end else if (wr_pend_q && !dly_sel[2]) begin
      if (hwdata[15:0] <= `OTFS_DLY_MAX) begin
        dly_q[dly_sel[1:0]] <= hwdata[15:0];
      end
    end
  end

endmodule

// [otfs_defs.svh]
// Constants of the output terminal function select block.
// Assumes a 125 MHz hclk and 32-bit AHB-Lite word registers.
`ifndef OTFS_DEFS_SVH
`define OTFS_DEFS_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define OTFS_A_MODE     8'h00
`define OTFS_A_FSW      8'h04
`define OTFS_A_RLY1     8'h08
`define OTFS_A_RLY2     8'h0C
`define OTFS_A_OC1      8'h10
`define OTFS_A_POL      8'h14
`define OTFS_A_DLY0     8'h18
`define OTFS_A_DLY1     8'h1C
`define OTFS_A_DLY2     8'h20
`define OTFS_A_DLY3     8'h24
`define OTFS_A_STAT     8'h28

// ----------------------------------------
// Reset values and limits
// ----------------------------------------
`define OTFS_RST_MODE   16'h0000
`define OTFS_RST_FSW    16'h0000
`define OTFS_RST_RLY1   16'h0003
`define OTFS_RST_RLY2   16'h0000
`define OTFS_RST_OC1    16'h0001
`define OTFS_RST_POL    4'h0
`define OTFS_RST_DLY    16'h0000
`define OTFS_MODE_MAX   16'h0001
`define OTFS_CODE_MAX   16'h0028
`define OTFS_CODE_LAST  16'h0014
`define OTFS_DLY_MAX    16'h8CA0

// ----------------------------------------
// Timing
// ----------------------------------------
`define OTFS_CLK_HZ        125000000
`define OTFS_PLC_PULSE_MS  250
`define OTFS_PLC_PULSE_CYC (`OTFS_PLC_PULSE_MS * (`OTFS_CLK_HZ / 1000))
`define OTFS_DLY_UNIT_MS   100
`define OTFS_TENTH_CYC     (`OTFS_DLY_UNIT_MS * (`OTFS_CLK_HZ / 1000))
`define OTFS_DRV_OVL_LEAD_S 10
`define OTFS_DRV_OVL_LEAD_DS (`OTFS_DRV_OVL_LEAD_S * 1000 / `OTFS_DLY_UNIT_MS)

`endif

// [otfs_pkg.sv]
// Types of the output terminal function select block.
// Assumes all status sources run on hclk.
package otfs_pkg;

  // ----------------------------------------
  // Drive status flags
  // ----------------------------------------
  typedef struct packed {
    logic fault_stop;
    logic motor_ovl_warn;
    logic drive_ovl_pending;
    logic running;
    logic freq_zero;
    logic at_upper;
    logic at_lower;
    logic freq_reached;
    logic freq_level_detect_one;
    logic set_above_upper;
    logic set_below_lower;
    logic speed_ctrl;
    logic torque_at_limit;
    logic stall;
    logic circuits_stable;
    logic fault_present;
    logic undervoltage;
    logic plc_cycle_done;
  } otfs_status_t;

  // ----------------------------------------
  // Drive measurements and setpoints
  // ----------------------------------------
  typedef struct packed {
    logic [15:0] count;
    logic [15:0] count_set;
    logic [15:0] count_desig;
    logic [15:0] length_act;
    logic [15:0] length_set;
    logic [15:0] run_time;
    logic [15:0] run_time_limit;
    logic [15:0] analog_input_one;
    logic [15:0] analog_input_two;
    logic [15:0] drive_ovl_eta;
  } otfs_meas_t;

endpackage

// [README_unused.sv]
`timescale 1ns/10ps

// [otfs_properties.sv]
// Checker of the output terminal function select bus and pin behaviour.
// Assumes it is bound to otfs_top, with hready fed from hreadyout.
`timescale 1ns/10ps
module otfs_properties (
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic        hready,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic        fast_terminal,
  input wire logic        relay_two,
  input wire logic        pulse_mode_output
);
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic rd_take;
  logic wr_take;
  assign rd_take = hsel && hready && htrans[1] && !hwrite;
  assign wr_take = hsel && hready && htrans[1] && hwrite;

  a_resp_okay: assert property (hresp == 1'b0)
    else $error("hresp not OKAY");
  a_read_wait: assert property (rd_take |=> !hreadyout ##1 hreadyout)
    else $error("read data phase not two cycles");
  a_write_nowait: assert property (wr_take |=> hreadyout)
    else $error("write data phase stalled");
  a_wait_cause: assert property ($fell(hreadyout) |-> $past(rd_take))
    else $error("wait state without a read");
  a_rdata_hold: assert property (!$stable(hrdata) |-> $rose(hreadyout))
    else $error("read data changed outside a read");
  a_upper_zero: assert property (hrdata[31:16] == 16'h0000)
    else $error("upper read bits not zero");
  a_fast_pulse_off: assert property (pulse_mode_output [*3] |-> !fast_terminal)
    else $error("fast terminal driven in pulse mode");
  a_reset_pins: assert property ($rose(hresetn) |-> pulse_mode_output && !relay_two)
    else $error("pins not at defaults after reset");
endmodule

// [otfs_drv_model.sv]
// Behavioural model of the relay and open-collector output drivers.
// Assumes pin levels from the terminal block, 1 meaning closed to common.
`timescale 1ns/10ps
module otfs_drv_model (
  input wire logic       hclk,
  input wire logic [3:0] pin_level,
  output logic     [3:0] contact_q
);
  // ----------------------------------------
  // Contacts
  // ----------------------------------------
  // Coil pulls in one cycle late, so checks must allow for it
  always_ff @(posedge hclk) begin
    contact_q <= pin_level;
  end
endmodule

// [output_terminal_function_select_test.sv]
// Self-checking bench of the output terminal function select block.
// Assumes otfs_top as the single AHB-Lite slave, driver model on its pins.
`timescale 1ns/10ps
module output_terminal_function_select_test;
  // ----------------------------------------
  // Signals and instances
  // ----------------------------------------
  localparam int PLC = 20;
  logic                   hclk = 1'b0;
  logic                   hresetn = 1'b0;
  logic                   hsel = 1'b0;
  logic [31:0]            haddr = 32'h0;
  logic [1:0]             htrans = 2'h0;
  logic                   hwrite = 1'b0;
  logic [2:0]             hsize = 3'h2;
  logic [31:0]            hwdata = 32'h0;
  logic [31:0]            hrdata;
  logic                   hreadyout;
  logic                   hresp;
  logic                   fast_terminal;
  logic                   relay_one;
  logic                   relay_two;
  logic                   open_collector_one;
  logic                   pulse_mode_output;
  otfs_pkg::otfs_status_t status = '0;
  otfs_pkg::otfs_meas_t   meas = '0;
  logic [3:0]             contact;
  logic [31:0]            rd;
  logic [3:0]             pol = 4'h0;
  int                     code = 0;
  int                     err_total = 0;
  int                     checks_done = 0;
  int                     cyc = 0;
  int                     hi = 0;

  otfs_top #(.PLC_PULSE_CYC(PLC), .TENTH_CYC(10)) otfs_top_inst (
    .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready(hreadyout), .hrdata, .hreadyout, .hresp, .status, .meas,
    .fast_terminal, .relay_one, .relay_two, .open_collector_one, .pulse_mode_output);
  otfs_drv_model otfs_drv_model_inst (.hclk, .contact_q(contact),
    .pin_level({open_collector_one, relay_two, relay_one, fast_terminal}));

  always #4 hclk = ~hclk;
  // Ceiling well above the roughly 1500 cycles the run needs
  always @(posedge hclk) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      finish_test();
    end
  end

  // ----------------------------------------
  // Tasks and functions
  // ----------------------------------------
  task automatic finish_test();
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    checks_done++;
    if (s !== e) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
    chk("response", {31'h0, hresp}, 32'h0);
  endtask

  function automatic logic cond(input int c, input otfs_pkg::otfs_status_t s,
                                input otfs_pkg::otfs_meas_t m);
    case (c)
      3: return s.fault_stop;
      4: return s.motor_ovl_warn;
      5: return s.drive_ovl_pending && m.drive_ovl_eta <= 16'h0064;
      6: return s.running && s.freq_zero;
      7: return s.freq_zero || !s.running;
      8: return s.running && s.at_upper;
      9: return s.running && s.at_lower;
      10: return m.count >= m.count_set;
      11: return m.count >= m.count_desig;
      12: return m.length_act > m.length_set;
      14: return m.run_time > m.run_time_limit;
      15: return (s.set_above_upper && s.at_upper) || (s.set_below_lower && s.at_lower);
      16: return s.speed_ctrl && s.torque_at_limit && s.stall;
      17: return s.circuits_stable && !s.fault_present && !s.undervoltage;
      18: return s.running;
      19: return m.analog_input_one > m.analog_input_two;
      20: return s.undervoltage;
      default: return 1'b0;
    endcase
  endfunction

  task automatic settle_chk();
    logic [31:0] s;
    logic [31:0] e;
    repeat (4) @(posedge hclk);
    for (int t = 0; t < 4; t++) begin
      s = {31'h0, contact[t]};
      e = {31'h0, cond(code, status, meas) ^ pol[t]};
      if (code < 11) chk("terminal", s, e);
      else chk("terminal", s, e);
    end
  endtask

  task automatic set_all(input int c);
    code = c;
    for (int t = 0; t < 4; t++) bus(1'b1, 32'h4 + 32'(4 * t), 32'(c));
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  logic [15:0] dflt [5] = '{16'h0000, 16'h0000, 16'h0003, 16'h0000, 16'h0001};
  initial begin
    void'($urandom(93));
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    for (int i = 0; i < 5; i++) begin
      bus(1'b0, 32'(4 * i), 32'h0);
      chk("reset value", rd, {16'h0, dflt[i]});
    end
    chk("pulse mode", {31'h0, pulse_mode_output}, 32'h1);
    bus(1'b0, 32'h3C, 32'h0);
    chk("unmapped", rd, 32'h0);
    bus(1'b1, 32'h0, 32'h1);
    bus(1'b1, 32'h0, 32'h2);
    bus(1'b0, 32'h0, 32'h0);
    chk("mode", rd, 32'h1);
    chk("pulse mode", {31'h0, pulse_mode_output}, 32'h0);
    bus(1'b1, 32'hC, 32'h29);
    bus(1'b0, 32'hC, 32'h0);
    chk("code over range", rd, 32'h0);
    for (int c = 0; c <= 40; c++) begin
      if (c == 1 || c == 2 || c == 13) continue;
      set_all(c);
      repeat (4) begin
        @(posedge hclk);
        status <= 18'($urandom);
        meas <= {$urandom, $urandom, $urandom, $urandom, $urandom};
        settle_chk();
      end
    end
    set_all(5);
    status.drive_ovl_pending <= 1'b1;
    meas.drive_ovl_eta <= 16'h0064;
    settle_chk();
    meas.drive_ovl_eta <= 16'h0065;
    settle_chk();
    set_all(10);
    meas.count <= 16'h0005;
    meas.count_set <= 16'h0005;
    settle_chk();
    bus(1'b1, 32'h14, 32'hF);
    pol = 4'hF;
    set_all(20);
    settle_chk();
    bus(1'b1, 32'h14, 32'h0);
    pol = 4'h0;
    status.undervoltage <= 1'b0;
    bus(1'b1, 32'h20, 32'h2);
    settle_chk();
    status.undervoltage <= 1'b1;
    repeat (5) @(posedge hclk);
    chk("delayed relay", {31'h0, relay_two}, 32'h0);
    repeat (30) @(posedge hclk);
    chk("delayed relay", {31'h0, relay_two}, 32'h1);
    bus(1'b1, 32'h24, 32'h8CA0);
    bus(1'b1, 32'h24, 32'h8CA1);
    bus(1'b0, 32'h24, 32'h0);
    chk("delay limit", rd, 32'h8CA0);
    set_all(13);
    status <= '0;
    @(posedge hclk);
    status.plc_cycle_done <= 1'b1;
    @(posedge hclk);
    status.plc_cycle_done <= 1'b0;
    repeat (40) begin
      @(posedge hclk);
      if (relay_one === 1'b1) hi++;
    end
    chk("cycle pulse width", 32'(hi), 32'(PLC));
    bus(1'b1, 32'h14, 32'h1);
    repeat (3) @(posedge hclk);
    chk("fast terminal", {31'h0, fast_terminal}, 32'h1);
    bus(1'b1, 32'h0, 32'h0);
    repeat (3) @(posedge hclk);
    chk("fast terminal", {31'h0, fast_terminal}, 32'h0);
    chk("pulse mode", {31'h0, pulse_mode_output}, 32'h1);
    finish_test();
  end
endmodule

bind otfs_top otfs_properties otfs_properties_inst (.hclk, .hresetn, .hsel, .hready, .htrans,
  .hwrite, .hrdata, .hreadyout, .hresp, .fast_terminal, .relay_two, .pulse_mode_output);
